// ===== rtl/acif_pkg.sv
// Package: operation codes, flag layout, register map and carriers of the flag datapath
//
// Functional notes
// RL1 - Accumulator-pair test subtracts second from first; sets N Z V C only.
// RL2 - Pair test: V on signed overflow, C on borrow, else cleared.
// RL3 - Clear-carry zeroes C only; clear-overflow zeroes V only.
// RL4 - Unmask-interrupt zeroes I, leaving H unchanged.
// RL5 - Zero-operand writes 00; Z set, N V C cleared, H I kept.
// RL6 - Acc-memory test subtracts memory from accumulator; sets N Z V C only.
// RL7 - Acc-memory test: C when memory exceeds accumulator unsigned, V on overflow.
// RL8 - Invert writes bitwise inverse; N Z from result, V cleared, C set.
// RL9 - Index test subtracts 16-bit memory word from index; sets N Z V C.
// RL10 - Index test: Z only when both byte differences are zero.
// RL11 - Index test: V from high-byte overflow, C when memory exceeds index.
// RL12 - BCD adjust adds 00/06/60/66 to first accumulator; C per table, N Z.
// RL13 - Minus-one subtracts one from operand; N Z V updated, C kept.
// RL14 - Minus-one: V exactly when operand was 80 hex.
// RL15 - Stack pointer decrement subtracts one; H untouched.
// RL16 - Index decrement subtracts one; only Z updated from sixteen bits.
// RL17 - XOR stores accumulator xor memory; N Z from result, V cleared, C kept.
// RL18 - Plus-one adds one to operand; N Z V updated, C kept.
// RL19 - Plus-one: V exactly when operand was 7F hex.
// RL20 - Stack pointer increment adds one; H untouched.
// RL21 - Index increment adds one; only Z updated from sixteen bits.
// RL22 - Eight-bit results: N copies bit 7, Z when all bits zero.
// RL23 - Flags an operation does not name keep their previous value.
package acif_pkg;

    // Operation codes
    typedef enum logic [4:0] {
        OP_ACC_PAIR_SUB_TEST = 5'h00,
        OP_CLEAR_CARRY       = 5'h01,
        OP_UNMASK_INTERRUPT  = 5'h02,
        OP_ZERO_OPERAND      = 5'h03,
        OP_CLEAR_OVERFLOW    = 5'h04,
        OP_ACC_MEM_SUB_TEST  = 5'h05,
        OP_INVERT_OPERAND    = 5'h06,
        OP_INDEX_SUB_TEST    = 5'h07,
        OP_BCD_ADJUST        = 5'h08,
        OP_MINUS_ONE         = 5'h09,
        OP_STACK_PTR_MINUS   = 5'h0a,
        OP_INDEX_MINUS       = 5'h0b,
        OP_XOR               = 5'h0c,
        OP_PLUS_ONE          = 5'h0d,
        OP_STACK_PTR_PLUS    = 5'h0e,
        OP_INDEX_PLUS        = 5'h0f
    } acif_op_t;

    // Flag positions inside the condition-code byte
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;
    localparam int FLAG_I = 4;
    localparam int FLAG_H = 5;
    localparam logic [7:0] CCR_MASK  = 8'h3f;
    localparam logic [7:0] CCR_RESET = 8'h10;

    // Register port map
    localparam logic [1:0] ADDR_CCR    = 2'h0;
    localparam logic [1:0] ADDR_RES8   = 2'h1;
    localparam logic [1:0] ADDR_RES_HI = 2'h2;
    localparam logic [1:0] ADDR_RES_LO = 2'h3;

    // Arithmetic constants
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    localparam logic [7:0]  BYTE_ONE   = 8'h01;
    localparam logic [7:0]  BYTE_ONES  = 8'hff;
    localparam logic [7:0]  DEC_OVF    = 8'h80;
    localparam logic [7:0]  INC_OVF    = 8'h7f;
    localparam logic [15:0] WORD_ONE   = 16'h0001;
    localparam logic [15:0] WORD_ZERO  = 16'h0000;
    localparam logic [3:0]  BCD_NINE   = 4'h9;
    localparam logic [3:0]  BCD_EIGHT  = 4'h8;
    localparam logic [7:0]  ADJ_LO     = 8'h06;
    localparam logic [7:0]  ADJ_HI     = 8'h60;

    // Operand carrier from the core
    typedef struct packed {
        logic [7:0]  acc_a;    // First accumulator
        logic [7:0]  acc_b;    // Second accumulator
        logic [15:0] index;    // Index register
        logic [15:0] sp;       // Stack pointer
        logic [7:0]  mem8;     // Byte memory operand
        logic [15:0] mem16;    // Word memory operand, high byte first address
        logic        sel_b;    // Selected accumulator is the second one
        logic        use_mem;  // One-operand ops act on memory
    } acif_operands_t;

    // Result carrier to the core
    typedef struct packed {
        logic [7:0]  res8;     // Byte result
        logic [15:0] res16;    // Word result
        logic        wr_acc_a; // Write res8 to first accumulator
        logic        wr_acc_b; // Write res8 to second accumulator
        logic        wr_mem;   // Write res8 to memory operand
        logic        wr_index; // Write res16 to index register
        logic        wr_sp;    // Write res16 to stack pointer
        logic        done;     // Operation completed
    } acif_result_t;

    // Register port request
    typedef struct packed {
        logic [1:0] addr;      // Register address
        logic [7:0] wdata;     // Write data
        logic       wr;        // Write strobe
        logic       rd;        // Read strobe
    } acif_bus_req_t;

endpackage : acif_pkg

// ===== rtl/acif_alu.sv
// Compare, clear, complement, BCD adjust, increment and decrement datapath with flags
//
// Our own choices: strobed register access and the address map.
module acif_alu (
    input  wire logic                    mclk,      // Core clock
    input  wire logic                    arst_n,    // Asynchronous reset, active low
    input  wire logic                    op_valid,  // Operation strobe
    input  wire acif_pkg::acif_op_t      op_code,   // Operation
    input  wire acif_pkg::acif_operands_t opnd,     // Operands
    input  wire acif_pkg::acif_bus_req_t bus,       // Register port request
    output logic [7:0]                   bus_rdata, // Read data, cycle after read
    output logic [7:0]                   ccr,       // Condition-code flags
    output acif_pkg::acif_result_t       result     // Result and write targets
);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [7:0]             ccr;
        logic [7:0]             rdata;
        acif_pkg::acif_result_t res;
    } acif_state_t;

    acif_state_t st;
    acif_state_t next_st;

    ////////////////////////////////////////////////////////////////////////
    // Subtract with borrow and signed overflow: {c, v, diff}
    function automatic logic [9:0] acif_sub8(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        logic       v;
        logic       c;
        r = a - b;
        v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        return {c, v, r};
    endfunction

    // Negative and zero from a byte result
    function automatic logic [1:0] acif_nz8(input logic [7:0] r);
        return {r[7], r == acif_pkg::BYTE_ZERO}; // [RL22]
    endfunction

    // Write targets of one-operand ops: first, second accumulator or memory
    function automatic logic [2:0] acif_tgt(input acif_pkg::acif_operands_t o);
        return {~o.use_mem & ~o.sel_b, ~o.use_mem & o.sel_b, o.use_mem};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [7:0]  f;
        logic [7:0]  src;
        logic [9:0]  sb;
        logic [7:0]  r;
        logic [15:0] w;
        logic [7:0]  lo_diff;
        logic [7:0]  hi_diff;
        logic        lo_borrow;
        logic [3:0]  hn;
        logic [3:0]  ln;
        logic        fix_lo;
        logic        fix_hi;
        logic [7:0]  adj;
        next_st = st;
        f = st.ccr;
        src = opnd.use_mem ? opnd.mem8 : (opnd.sel_b ? opnd.acc_b : opnd.acc_a);
        sb = 10'h000;
        r = 8'h00;
        w = 16'h0000;
        lo_diff = 8'h00;
        hi_diff = 8'h00;
        lo_borrow = 1'b0;
        hn = opnd.acc_a[7:4];
        ln = opnd.acc_a[3:0];
        fix_lo = 1'b0;
        fix_hi = 1'b0;
        adj = 8'h00;
        next_st.res.wr_acc_a = 1'b0;
        next_st.res.wr_acc_b = 1'b0;
        next_st.res.wr_mem = 1'b0;
        next_st.res.wr_index = 1'b0;
        next_st.res.wr_sp = 1'b0;
        next_st.res.done = 1'b0;
        next_st.rdata = 8'h00;

        // Register port read, answered next cycle; unmapped bits read zero
        if (bus.rd) begin
            unique case (bus.addr)
                acif_pkg::ADDR_CCR:    next_st.rdata = st.ccr & acif_pkg::CCR_MASK;
                acif_pkg::ADDR_RES8:   next_st.rdata = st.res.res8;
                acif_pkg::ADDR_RES_HI: next_st.rdata = st.res.res16[15:8];
                acif_pkg::ADDR_RES_LO: next_st.rdata = st.res.res16[7:0];
            endcase
        end
        // Software write to the flags; an operation in the same cycle overrides only the flags it writes
        if (bus.wr && bus.addr == acif_pkg::ADDR_CCR) begin
            f = bus.wdata & acif_pkg::CCR_MASK;
        end

        if (op_valid) begin
            next_st.res.done = 1'b1;
            unique case (op_code)
                acif_pkg::OP_ACC_PAIR_SUB_TEST: begin
                    sb = acif_sub8(opnd.acc_a, opnd.acc_b); // [RL1]
                    next_st.res.res8 = sb[7:0];
                    {f[acif_pkg::FLAG_N], f[acif_pkg::FLAG_Z]} = acif_nz8(sb[7:0]);
                    f[acif_pkg::FLAG_V] = sb[8]; // [RL2]
                    f[acif_pkg::FLAG_C] = sb[9]; // [RL2]
                end
                acif_pkg::OP_CLEAR_CARRY: begin
                    f[acif_pkg::FLAG_C] = 1'b0; // [RL3]
                end
                acif_pkg::OP_CLEAR_OVERFLOW: begin
                    f[acif_pkg::FLAG_V] = 1'b0; // [RL3]
                end
                acif_pkg::OP_UNMASK_INTERRUPT: begin
                    f[acif_pkg::FLAG_I] = 1'b0; // [RL4]
                end
                acif_pkg::OP_ZERO_OPERAND: begin
                    next_st.res.res8 = acif_pkg::BYTE_ZERO; // [RL5]
                    {next_st.res.wr_acc_a, next_st.res.wr_acc_b, next_st.res.wr_mem} = acif_tgt(opnd);
                    f[acif_pkg::FLAG_N] = 1'b0; // [RL5]
                    f[acif_pkg::FLAG_Z] = 1'b1; // [RL5]
                    f[acif_pkg::FLAG_V] = 1'b0; // [RL5]
                    f[acif_pkg::FLAG_C] = 1'b0; // [RL5]
                end
                acif_pkg::OP_ACC_MEM_SUB_TEST: begin
                    src = opnd.sel_b ? opnd.acc_b : opnd.acc_a;
                    sb = acif_sub8(src, opnd.mem8); // [RL6]
                    next_st.res.res8 = sb[7:0];
                    {f[acif_pkg::FLAG_N], f[acif_pkg::FLAG_Z]} = acif_nz8(sb[7:0]);
                    f[acif_pkg::FLAG_V] = sb[8]; // [RL7]
                    f[acif_pkg::FLAG_C] = sb[9]; // [RL7]
                end
                acif_pkg::OP_INVERT_OPERAND: begin
                    r = acif_pkg::BYTE_ONES ^ src; // [RL8]
                    next_st.res.res8 = r;
                    {next_st.res.wr_acc_a, next_st.res.wr_acc_b, next_st.res.wr_mem} = acif_tgt(opnd);
                    {f[acif_pkg::FLAG_N], f[acif_pkg::FLAG_Z]} = acif_nz8(r);
                    f[acif_pkg::FLAG_V] = 1'b0; // [RL8]
                    f[acif_pkg::FLAG_C] = 1'b1; // [RL8]
                end
                acif_pkg::OP_INDEX_SUB_TEST: begin
                    // Low byte first, its borrow feeds the high byte
                    lo_diff = opnd.index[7:0] - opnd.mem16[7:0]; // [RL9]
                    lo_borrow = opnd.index[7:0] < opnd.mem16[7:0];
                    hi_diff = opnd.index[15:8] - opnd.mem16[15:8] - {7'h00, lo_borrow};
                    w = {hi_diff, lo_diff};
                    next_st.res.res16 = w;
                    f[acif_pkg::FLAG_N] = w[15];
                    f[acif_pkg::FLAG_Z] = (hi_diff == acif_pkg::BYTE_ZERO)
                                        & (lo_diff == acif_pkg::BYTE_ZERO); // [RL10]
                    f[acif_pkg::FLAG_V] = (opnd.index[15] & ~opnd.mem16[15] & ~hi_diff[7])
                        | (~opnd.index[15] & opnd.mem16[15] & hi_diff[7]); // [RL11]
                    f[acif_pkg::FLAG_C] = opnd.mem16 > opnd.index; // [RL11]
                end
                acif_pkg::OP_BCD_ADJUST: begin
                    // Correction chosen from prior carry, half-carry and nibbles
                    fix_lo = f[acif_pkg::FLAG_H] | (ln > acif_pkg::BCD_NINE); // [RL12]
                    fix_hi = f[acif_pkg::FLAG_C] | (hn > acif_pkg::BCD_NINE)
                           | ((hn > acif_pkg::BCD_EIGHT) & (ln > acif_pkg::BCD_NINE));
                    adj = (fix_lo ? acif_pkg::ADJ_LO : acif_pkg::BYTE_ZERO)
                        | (fix_hi ? acif_pkg::ADJ_HI : acif_pkg::BYTE_ZERO);
                    r = opnd.acc_a + adj; // [RL12]
                    next_st.res.res8 = r;
                    next_st.res.wr_acc_a = 1'b1;
                    {f[acif_pkg::FLAG_N], f[acif_pkg::FLAG_Z]} = acif_nz8(r);
                    f[acif_pkg::FLAG_C] = fix_hi; // [RL12]
                end
                acif_pkg::OP_MINUS_ONE: begin
                    r = src - acif_pkg::BYTE_ONE; // [RL13]
                    next_st.res.res8 = r;
                    {next_st.res.wr_acc_a, next_st.res.wr_acc_b, next_st.res.wr_mem} = acif_tgt(opnd);
                    {f[acif_pkg::FLAG_N], f[acif_pkg::FLAG_Z]} = acif_nz8(r);
                    f[acif_pkg::FLAG_V] = src == acif_pkg::DEC_OVF; // [RL14]
                end
                acif_pkg::OP_PLUS_ONE: begin
                    r = src + acif_pkg::BYTE_ONE; // [RL18]
                    next_st.res.res8 = r;
                    {next_st.res.wr_acc_a, next_st.res.wr_acc_b, next_st.res.wr_mem} = acif_tgt(opnd);
                    {f[acif_pkg::FLAG_N], f[acif_pkg::FLAG_Z]} = acif_nz8(r);
                    f[acif_pkg::FLAG_V] = src == acif_pkg::INC_OVF; // [RL19]
                end
                acif_pkg::OP_STACK_PTR_MINUS: begin
                    next_st.res.res16 = opnd.sp - acif_pkg::WORD_ONE; // [RL15]
                    next_st.res.wr_sp = 1'b1;
                end
                acif_pkg::OP_STACK_PTR_PLUS: begin
                    next_st.res.res16 = opnd.sp + acif_pkg::WORD_ONE; // [RL20]
                    next_st.res.wr_sp = 1'b1;
                end
                acif_pkg::OP_INDEX_MINUS: begin
                    w = opnd.index - acif_pkg::WORD_ONE; // [RL16]
                    next_st.res.res16 = w;
                    next_st.res.wr_index = 1'b1;
                    f[acif_pkg::FLAG_Z] = w == acif_pkg::WORD_ZERO; // [RL16]
                end
                acif_pkg::OP_INDEX_PLUS: begin
                    w = opnd.index + acif_pkg::WORD_ONE; // [RL21]
                    next_st.res.res16 = w;
                    next_st.res.wr_index = 1'b1;
                    f[acif_pkg::FLAG_Z] = w == acif_pkg::WORD_ZERO; // [RL21]
                end
                acif_pkg::OP_XOR: begin
                    src = opnd.sel_b ? opnd.acc_b : opnd.acc_a;
                    r = src ^ opnd.mem8; // [RL17]
                    next_st.res.res8 = r;
                    next_st.res.wr_acc_a = ~opnd.sel_b;
                    next_st.res.wr_acc_b = opnd.sel_b;
                    {f[acif_pkg::FLAG_N], f[acif_pkg::FLAG_Z]} = acif_nz8(r);
                    f[acif_pkg::FLAG_V] = 1'b0; // [RL17]
                end
                default: begin
                    next_st.res.done = 1'b0;
                end
            endcase
        end
        // Untouched flags keep their value through every path above
        next_st.ccr = f; // [RL23]
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
            st.ccr <= acif_pkg::CCR_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state
    assign bus_rdata = st.rdata;
    assign ccr = st.ccr;
    assign result = st.res;

endmodule : acif_alu // acif_alu

// ===== test/acif_alu_monitor.sv
// Concurrent checks of the flag datapath, bound to its ports
module acif_alu_monitor (
    input wire logic                     mclk,      // Core clock
    input wire logic                     arst_n,    // Reset, active low
    input wire logic                     op_valid,  // Operation strobe
    input wire acif_pkg::acif_op_t       op_code,   // Operation
    input wire acif_pkg::acif_operands_t opnd,      // Operands
    input wire acif_pkg::acif_bus_req_t  bus,       // Register port
    input wire logic [7:0]               bus_rdata, // Read data
    input wire logic [7:0]               ccr,       // Flags
    input wire acif_pkg::acif_result_t   result     // Results
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sel; // Selected accumulator
    logic [7:0] tgt; // One-operand target
    logic       nwr; // No flag write beside the op
    // Operand selection and flag write guard
    assign sel = opnd.sel_b ? opnd.acc_b : opnd.acc_a;
    assign tgt = opnd.use_mem ? opnd.mem8 : sel;
    assign nwr = !(bus.wr && bus.addr == acif_pkg::ADDR_CCR);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // An accepted operation with no flag write beside it
    sequence s_op(acif_pkg::acif_op_t code);
        op_valid && op_code == code && nwr;
    endsequence
    chk_pair_borrow: assert property (s_op(acif_pkg::OP_ACC_PAIR_SUB_TEST) |=>
        ccr[0] == ($past(opnd.acc_b) > $past(opnd.acc_a)) && ccr[5:4] == $past(ccr[5:4]))
        else $error("pair test carry or kept flags wrong");
    chk_mem_borrow: assert property (s_op(acif_pkg::OP_ACC_MEM_SUB_TEST) |=>
        ccr[0] == ($past(opnd.mem8) > $past(sel)))
        else $error("memory test carry wrong");
    chk_carry_clear: assert property (s_op(acif_pkg::OP_CLEAR_CARRY) |=>
        ccr == ($past(ccr) & 8'hfe))
        else $error("clear carry touched other flags");
    chk_ovf_clear: assert property (s_op(acif_pkg::OP_CLEAR_OVERFLOW) |=>
        ccr == ($past(ccr) & 8'hfd))
        else $error("clear overflow touched other flags");
    chk_mask_clear: assert property (s_op(acif_pkg::OP_UNMASK_INTERRUPT) |=>
        ccr == ($past(ccr) & 8'hef))
        else $error("unmask touched other flags");
    chk_zero_flags: assert property (s_op(acif_pkg::OP_ZERO_OPERAND) |=>
        ccr[3:0] == 4'h4 && result.res8 == 8'h00 && ccr[5:4] == $past(ccr[5:4]))
        else $error("zero operand flags wrong");
    chk_invert_flags: assert property (s_op(acif_pkg::OP_INVERT_OPERAND) |=>
        ccr[1:0] == 2'b01 && result.res8 == ~$past(tgt) && ccr[3] == result.res8[7])
        else $error("invert result or flags wrong");
    chk_dec_ovf: assert property (s_op(acif_pkg::OP_MINUS_ONE) |=>
        ccr[1] == ($past(tgt) == 8'h80) && ccr[0] == $past(ccr[0]))
        else $error("minus one overflow or carry wrong");
    chk_inc_ovf: assert property (s_op(acif_pkg::OP_PLUS_ONE) |=>
        ccr[1] == ($past(tgt) == 8'h7f) && ccr[0] == $past(ccr[0]))
        else $error("plus one overflow or carry wrong");
    chk_index_inc: assert property (s_op(acif_pkg::OP_INDEX_PLUS) |=>
        ccr[2] == ($past(opnd.index) == 16'hffff) && (ccr & 8'hfb) == ($past(ccr) & 8'hfb))
        else $error("index increment flags wrong");
    chk_index_dec: assert property (s_op(acif_pkg::OP_INDEX_MINUS) |=>
        ccr[2] == ($past(opnd.index) == 16'h0001) && (ccr & 8'hfb) == ($past(ccr) & 8'hfb))
        else $error("index decrement flags wrong");
endmodule // acif_alu_monitor

bind acif_alu acif_alu_monitor u_mon (.mclk(mclk), .arst_n(arst_n), .op_valid(op_valid),
    .op_code(op_code), .opnd(opnd), .bus(bus), .bus_rdata(bus_rdata), .ccr(ccr),
    .result(result));

// ===== test/tb_alu_compare_incdec_flags.sv
// Self-checking bench of the flag datapath with corner and random operations
module tb_alu_compare_incdec_flags;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     mclk;        // Clock
    logic                     arst_n;      // Reset, active low
    logic                     op_valid;    // Operation strobe
    acif_pkg::acif_op_t       op_code;     // Operation
    acif_pkg::acif_operands_t opnd;        // Operands
    acif_pkg::acif_bus_req_t  bus;         // Register port
    logic [7:0]               bus_rdata;   // Read data
    logic [7:0]               ccr;         // Flags
    acif_pkg::acif_result_t   result;      // Results
    logic [7:0]               e_ccr;       // Expected flags
    logic [7:0]               e8;          // Expected byte result
    logic [15:0]              e16;         // Expected word result
    logic [5:0]               e_wr;        // Expected enables
    logic                     c8;          // Byte result defined
    logic                     c16;         // Word result defined
    logic [31:0]              seed;        // Random state
    int                       n_errors;    // Mismatches
    int                       checks_done; // Comparisons

    acif_alu dut (.mclk(mclk), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
                  .opnd(opnd), .bus(bus), .bus_rdata(bus_rdata), .ccr(ccr), .result(result));

    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Xorshift source and random operands
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic acif_pkg::acif_operands_t rnd();
        logic [95:0] r;
        r = {xs(), xs(), xs()};
        return r[$bits(acif_pkg::acif_operands_t)-1:0];
    endfunction
    // Compare and count
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Expected flags, results and enables of one operation
    task automatic predict(input acif_pkg::acif_op_t op, input acif_pkg::acif_operands_t p);
        logic [7:0] s, t, m;
        logic       lf, hf;
        s = p.sel_b ? p.acc_b : p.acc_a;
        t = p.use_mem ? p.mem8 : s;
        m = p.mem8;
        c8 = 1'b1;
        c16 = 1'b0;
        e_wr = {p.use_mem ? 3'b001 : (p.sel_b ? 3'b010 : 3'b100), 3'b001};
        case (op)
            acif_pkg::OP_ACC_PAIR_SUB_TEST, acif_pkg::OP_ACC_MEM_SUB_TEST: begin
                if (op == acif_pkg::OP_ACC_PAIR_SUB_TEST) {s, m} = {p.acc_a, p.acc_b};
                e8 = s - m;
                e_ccr[1] = (s[7] & ~m[7] & ~e8[7]) | (~s[7] & m[7] & e8[7]);
                e_ccr[0] = m > s;
                e_wr = 6'h01;
            end
            acif_pkg::OP_INDEX_SUB_TEST: begin
                e16 = p.index - p.mem16;
                e_ccr[3:2] = {e16[15], e16 == 16'h0000};
                e_ccr[1] = (p.index[15] & ~p.mem16[15] & ~e16[15])
                         | (~p.index[15] & p.mem16[15] & e16[15]);
                e_ccr[0] = p.mem16 > p.index;
                {c8, c16, e_wr} = {2'b01, 6'h01};
            end
            acif_pkg::OP_CLEAR_CARRY: {c8, e_wr, e_ccr[0]} = 8'h02;
            acif_pkg::OP_CLEAR_OVERFLOW: {c8, e_wr, e_ccr[1]} = 8'h02;
            acif_pkg::OP_UNMASK_INTERRUPT: {c8, e_wr, e_ccr[4]} = 8'h02;
            acif_pkg::OP_ZERO_OPERAND: {e8, e_ccr[1:0]} = 10'h000;
            acif_pkg::OP_INVERT_OPERAND: {e8, e_ccr[1:0]} = {~t, 2'b01};
            acif_pkg::OP_BCD_ADJUST: begin
                lf = e_ccr[5] | (p.acc_a[3:0] > 4'h9);
                hf = e_ccr[0] | (p.acc_a[7:4] > 4'h9) | (p.acc_a[7:4] > 4'h8 && p.acc_a[3:0] > 4'h9);
                e8 = p.acc_a + (lf ? 8'h06 : 8'h00) + (hf ? 8'h60 : 8'h00);
                {e_ccr[0], e_wr} = {hf, 6'h21};
            end
            acif_pkg::OP_MINUS_ONE: {e8, e_ccr[1]} = {t - 8'h01, t == 8'h80};
            acif_pkg::OP_PLUS_ONE: {e8, e_ccr[1]} = {t + 8'h01, t == 8'h7f};
            acif_pkg::OP_XOR: {e8, e_ccr[1], e_wr} = {s ^ m, 1'b0, p.sel_b ? 6'h11 : 6'h21};
            acif_pkg::OP_STACK_PTR_MINUS: {e16, c8, e_wr} = {p.sp - 16'h0001, 7'h03};
            acif_pkg::OP_STACK_PTR_PLUS: {e16, c8, e_wr} = {p.sp + 16'h0001, 7'h03};
            acif_pkg::OP_INDEX_MINUS: {e16, c8, e_wr} = {p.index - 16'h0001, 7'h05};
            acif_pkg::OP_INDEX_PLUS: {e16, c8, e_wr} = {p.index + 16'h0001, 7'h05};
            default: {c8, e_wr} = 7'h00;
        endcase
        c16 = c16 | (e_wr[2:1] != 2'b00);
        if (e_wr[2]) e_ccr[2] = e16 == 16'h0000;
        if (c8) e_ccr[3:2] = {e8[7], e8 == 8'h00};
    endtask
    // Issue one operation and compare its outcome the cycle after
    task automatic run_op(input acif_pkg::acif_op_t op, input acif_pkg::acif_operands_t p);
        predict(op, p);
        @(posedge mclk);
        op_valid <= 1'b1;
        op_code <= op;
        opnd <= p;
        @(posedge mclk);
        op_valid <= 1'b0;
        @(negedge mclk);
        check("ccr", {8'h00, e_ccr}, {8'h00, ccr});
        check("enables", {10'h000, e_wr}, {10'h000, result[5:0]});
        if (c8) check("res8", {8'h00, e8}, {8'h00, result.res8});
        if (c16) check("res16", e16, result.res16);
    endtask
    // Corner operation with chosen operands; second accumulator mirrors the memory byte
    task automatic cx(input acif_pkg::acif_op_t op, input logic [7:0] a, input logic [7:0] m,
                      input logic [1:0] su = 2'b00, input logic [15:0] ix = 16'h0000,
                      input logic [15:0] mw = 16'h0000);
        run_op(op, {a, m, ix, ix, m, mw, su});
    endtask
    // One register port access; for a read, d is the expected data
    task automatic bus_op(input logic w, input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= {a, d, w, ~w};
        @(posedge mclk);
        bus <= {a, d, 2'b00};
        @(negedge mclk);
        if (w && a == acif_pkg::ADDR_CCR) e_ccr = d & 8'h3f;
        if (!w) check("bus_rdata", {8'h00, d}, {8'h00, bus_rdata});
    endtask
    // Report counts and end the run
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {arst_n, op_valid, opnd, bus} = '0;
        op_code = acif_pkg::OP_ACC_PAIR_SUB_TEST;
        seed = 32'd55;
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        @(negedge mclk);
        check("reset ccr", 16'h0010, {8'h00, ccr});
        check("reset enables", 16'h0000, {10'h000, result[5:0]});
        e_ccr = 8'h10;
        bus_op(1'b0, acif_pkg::ADDR_CCR, 8'h10);
        bus_op(1'b1, acif_pkg::ADDR_CCR, 8'hff);
        bus_op(1'b0, acif_pkg::ADDR_CCR, 8'h3f);
        bus_op(1'b1, acif_pkg::ADDR_RES8, 8'h5a);
        bus_op(1'b0, acif_pkg::ADDR_RES8, 8'h00);
        cx(acif_pkg::OP_PLUS_ONE, 8'h7f, 8'h00);
        cx(acif_pkg::OP_MINUS_ONE, 8'h00, 8'h80, 2'b01);
        cx(acif_pkg::OP_MINUS_ONE, 8'h00, 8'h80);
        cx(acif_pkg::OP_PLUS_ONE, 8'h00, 8'hff, 2'b10);
        cx(acif_pkg::OP_INDEX_SUB_TEST, 8'h00, 8'h00, 2'b00, 16'h1234, 16'h1234);
        cx(acif_pkg::OP_INDEX_SUB_TEST, 8'h00, 8'h00, 2'b00, 16'h1234, 16'h1334);
        cx(acif_pkg::OP_INDEX_SUB_TEST, 8'h00, 8'h00, 2'b00, 16'h1234, 16'h1235);
        cx(acif_pkg::OP_INDEX_SUB_TEST, 8'h00, 8'h00, 2'b00, 16'h8000, 16'h0001);
        bus_op(1'b0, acif_pkg::ADDR_RES_HI, e16[15:8]);
        cx(acif_pkg::OP_INDEX_MINUS, 8'h00, 8'h00, 2'b00, 16'h0001);
        cx(acif_pkg::OP_INDEX_PLUS, 8'h00, 8'h00, 2'b00, 16'hffff);
        cx(acif_pkg::OP_ACC_PAIR_SUB_TEST, 8'h80, 8'h01);
        cx(acif_pkg::OP_ACC_MEM_SUB_TEST, 8'h10, 8'h20);
        cx(acif_pkg::OP_ZERO_OPERAND, 8'h55, 8'h66, 2'b10);
        cx(acif_pkg::OP_BCD_ADJUST, 8'h9a, 8'h00);
        cx(acif_pkg::acif_op_t'(5'h1f), 8'h00, 8'h00);
        for (int i = 0; i < 600; i++) begin
            if (i % 8 == 0) bus_op(1'b1, acif_pkg::ADDR_CCR, 8'(xs()));
            run_op(acif_pkg::acif_op_t'(5'(xs() % 17)), rnd());
            if (i % 16 == 0) bus_op(1'b0, acif_pkg::ADDR_RES_LO, e16[7:0]);
        end
        give_verdict();
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        give_verdict();
    end
endmodule // tb_alu_compare_incdec_flags
